// ===== shared/mop_pkg.sv
// constants, types and register map of the motor overload protection block
// What this block does
// - locked passcode blocks keypad up/down edits
// - locked Modbus parameter write answers exception 03
// - passcode four BCD digits, msd first, enter each
// - show On/Off; fourth digit stores and locks
// - matching code clears lock, other ignored
// - faults logged, newest first, nine deep
// - class heating only above FLA times SF, hot/cold tracking below
// - forty trip classes in steps of one
// - class equals trip seconds at 600 percent
// - separate start and run classes, each disableable
// - alarm at 90 percent content
// - trip fault at 100 percent content
// - controlled stop profile before stop if enabled
// - trip time within 0.2 s or 3 percent
// - starts refused until content below 15 percent
// - imbalance derate speeds up heating
// - imbalance derate also raises steady-state level
// - rate follows phase and its class
// - content readable on display and bus
// - start class until up-to-speed, content kept
// - independent select off uses running class
// - disabled class clamps 99, both off zero
package mop_pkg;
  localparam int unsigned TICK_HZ     = 100;
  // content units: 100 percent is reached by 600 percent current in one
  // second per class step, since one tick adds current_pct squared / class
  localparam logic [31:0] CONT_FULL   = 32'(360000 * TICK_HZ);
  localparam logic [31:0] CONT_PCT    = CONT_FULL / 32'h0000_0064;
  localparam logic [31:0] CONT_ALARM  = CONT_PCT * 32'h0000_005A;
  localparam logic [31:0] CONT_CLAMP  = CONT_PCT * 32'h0000_0063;
  localparam logic [31:0] CONT_LOCK   = CONT_PCT * 32'h0000_000F;
  localparam logic [5:0]  CLASS_MAX   = 6'h28;
  localparam logic [7:0]  PCT_ONE     = 8'h64;
  localparam int unsigned COOL_SHIFT  = 8;
  localparam logic [7:0]  FAULT_OL    = 8'h01;
  localparam logic [3:0]  EXC_ILLEGAL = 4'h3;
  localparam logic [3:0]  DIGIT_MAX   = 4'h9;
  localparam logic [1:0]  DIGIT_LAST  = 2'h3;
  localparam int unsigned LOG_DEPTH   = 9;
  // register byte offsets
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_CLASS  = 8'h04;
  localparam logic [7:0] REG_FLC    = 8'h08;
  localparam logic [7:0] REG_SF     = 8'h0C;
  localparam logic [7:0] REG_HCR    = 8'h10;
  localparam logic [7:0] REG_STAT   = 8'h14;
  localparam logic [7:0] REG_LOG    = 8'h20;
  localparam logic [7:0] REG_LOG_END = 8'h40;
  // reset values
  localparam logic [15:0] FLC_RST   = 16'h0064;
  localparam logic [7:0]  SF_RST    = 8'h64;
  localparam logic [7:0]  HCR_RST   = 8'h3C;
  localparam logic [5:0]  CLASS_RST = 6'h0A;
  typedef enum logic [2:0] {
    PH_STOPPED, PH_KICK, PH_ACCEL, PH_RUN_PRE_UTS, PH_UP_TO_SPEED, PH_DECEL
  } mop_phase_t;
  typedef struct packed {
    logic up;
    logic down;
    logic enter;
    logic lock_sel;
  } mop_keys_t;
  typedef struct packed {
    logic        indep;
    logic        ctrl_stop;
    logic [5:0]  start_class;
    logic [5:0]  run_class;
    logic [15:0] flc;
    logic [7:0]  sf;
    logic [7:0]  hcr;
  } mop_cfg_t;
endpackage

// ===== rtl/mop_fault_log.sv
// nine-entry fault history, newest at index zero
`timescale 1ns/10ps
module mop_fault_log #(
  parameter int unsigned DEPTH = mop_pkg::LOG_DEPTH
) (
  // clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // push side
  input  wire logic       push_i,
  input  wire logic [7:0] code_i,
  // read side
  input  wire logic [3:0] rd_idx_i,
  output logic      [7:0] rd_data_o,
  output logic      [7:0] newest_o
);
  logic [7:0] entry      [DEPTH];
  logic [7:0] next_entry [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_entry[i] = entry[i];
    end
    if (push_i) begin
      next_entry[0] = code_i;
      for (int i = 1; i < DEPTH; i++) begin
        next_entry[i] = entry[i-1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry[i] <= 8'h00;
      end
    end else if (ce_i) begin
      entry <= next_entry;
    end
  end

  assign rd_data_o = (32'(rd_idx_i) < DEPTH) ? entry[rd_idx_i] : 8'h00;
  assign newest_o  = entry[0];
endmodule

// ===== rtl/mop_protect.sv
// overload accumulator, passcode lock and register slave of the starter
`timescale 1ns/10ps
module mop_protect (
  // clock and control
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // keypad
  input  wire mop_pkg::mop_keys_t  keys_i,
  output logic                     param_inc_o,
  output logic                     param_dec_o,
  output logic                     lock_on_o,
  output logic      [3:0]          entry_digit_o,
  output logic      [1:0]          entry_idx_o,
  // measurement and starter state
  input  wire logic                tick_i,
  input  wire logic [15:0]         current_i,
  input  wire logic [7:0]          derate_i,
  input  wire mop_pkg::mop_phase_t starter_phase_i,
  input  wire logic                fault_i,
  input  wire logic [7:0]          fault_code_i,
  // protection outputs
  output logic      [6:0]          content_pct_o,
  output logic                     alarm_o,
  output logic                     trip_o,
  output logic                     stop_profile_o,
  output logic                     stop_now_o,
  output logic                     start_inhibit_o
);
  function automatic logic [31:0] ratio_pct(input logic [31:0] num, input logic [31:0] den);
    ratio_pct = (den == 32'h0) ? 32'h0 : (num * 32'h64) / den;
  endfunction

  // ---------------- registers and bus
  mop_pkg::mop_cfg_t cfg, next_cfg;
  logic [3:0]  exc, next_exc;
  logic [31:0] next_dat;
  logic        next_ack;
  logic [31:0] content, next_content;
  logic        trip, next_trip;
  logic        stop_prof, next_stop_prof;
  logic        locked, next_locked;
  logic [7:0]  log_rd;
  logic [7:0]  log_newest;
  logic        param_adr;
  logic        wr_take;
  logic        alarm;

  assign param_adr = (adr_i <= mop_pkg::REG_HCR);
  assign wr_take   = cyc_i && stb_i && we_i && ack_o;

  always_comb begin
    next_cfg = cfg;
    next_exc = exc;
    next_ack = cyc_i && stb_i && !ack_o;
    next_dat = 32'h0;
    if (wr_take && param_adr) begin
      if (locked) begin
        next_exc = mop_pkg::EXC_ILLEGAL;
      end else begin
        next_exc = 4'h0;
        case (adr_i)
          mop_pkg::REG_CFG: begin
            if (sel_i[0]) begin
              next_cfg.indep     = dat_i[0];
              next_cfg.ctrl_stop = dat_i[1];
            end
          end
          mop_pkg::REG_CLASS: begin
            // classes above forty are not taken
            if (sel_i[0] && dat_i[5:0] <= mop_pkg::CLASS_MAX) begin
              next_cfg.start_class = dat_i[5:0];
            end
            if (sel_i[1] && dat_i[13:8] <= mop_pkg::CLASS_MAX) begin
              next_cfg.run_class = dat_i[13:8];
            end
          end
          mop_pkg::REG_FLC: begin
            if (sel_i[0]) next_cfg.flc[7:0] = dat_i[7:0];
            if (sel_i[1]) next_cfg.flc[15:8] = dat_i[15:8];
          end
          mop_pkg::REG_SF: begin
            if (sel_i[0]) next_cfg.sf = dat_i[7:0];
          end
          mop_pkg::REG_HCR: begin
            if (sel_i[0]) next_cfg.hcr = dat_i[7:0];
          end
          default: begin
          end
        endcase
      end
    end
    if (cyc_i && stb_i && !ack_o && !we_i) begin
      case (adr_i)
        mop_pkg::REG_CFG:   next_dat = {30'h0, cfg.ctrl_stop, cfg.indep};
        mop_pkg::REG_CLASS: next_dat = {18'h0, cfg.run_class, 2'h0, cfg.start_class};
        mop_pkg::REG_FLC:   next_dat = {16'h0, cfg.flc};
        mop_pkg::REG_SF:    next_dat = {24'h0, cfg.sf};
        mop_pkg::REG_HCR:   next_dat = {24'h0, cfg.hcr};
        mop_pkg::REG_STAT:  next_dat = {12'h0, exc, 4'h0, locked, start_inhibit_o,
                                        trip, alarm, 1'b0, content_pct_o};
        default: begin
          if (adr_i >= mop_pkg::REG_LOG && adr_i <= mop_pkg::REG_LOG_END) begin
            next_dat = {24'h0, log_rd};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg   <= '{indep: 1'b0, ctrl_stop: 1'b0, start_class: mop_pkg::CLASS_RST,
                 run_class: mop_pkg::CLASS_RST, flc: mop_pkg::FLC_RST,
                 sf: mop_pkg::SF_RST, hcr: mop_pkg::HCR_RST};
      exc   <= 4'h0;
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (ce_i) begin
      cfg   <= next_cfg;
      exc   <= next_exc;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ---------------- passcode entry
  typedef enum logic {PC_VIEW, PC_ENTRY} mop_pc_t;
  mop_pc_t     pc, next_pc;
  logic [15:0] code, next_code;
  logic [15:0] entry, next_entry;
  logic [3:0]  digit, next_digit;
  logic [1:0]  idx, next_idx;
  logic [15:0] full_entry;

  assign full_entry = {entry[11:0], digit};

  always_comb begin
    next_pc     = pc;
    next_code   = code;
    next_entry  = entry;
    next_digit  = digit;
    next_idx    = idx;
    next_locked = locked;
    case (pc)
      PC_VIEW: begin
        if (keys_i.lock_sel && keys_i.enter) begin
          next_pc    = PC_ENTRY;
          next_entry = 16'h0;
          next_digit = 4'h0;
          next_idx   = 2'h0;
        end
      end
      PC_ENTRY: begin
        // one decimal digit at a time, msd first
        if (!keys_i.lock_sel) begin
          next_pc = PC_VIEW;
        end else if (keys_i.enter) begin
          next_entry = full_entry;
          next_digit = 4'h0;
          next_idx   = idx + 2'h1;
          if (idx == mop_pkg::DIGIT_LAST) begin
            next_pc = PC_VIEW;
            if (!locked) begin
              next_code   = full_entry;
              next_locked = 1'b1;
            end else if (full_entry == code) begin
              next_locked = 1'b0;
            end
          end
        end else if (keys_i.up) begin
          next_digit = (digit == mop_pkg::DIGIT_MAX) ? 4'h0 : digit + 4'h1;
        end else if (keys_i.down) begin
          next_digit = (digit == 4'h0) ? mop_pkg::DIGIT_MAX : digit - 4'h1;
        end
      end
      default: next_pc = PC_VIEW;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc     <= PC_VIEW;
      code   <= 16'h0;
      entry  <= 16'h0;
      digit  <= 4'h0;
      idx    <= 2'h0;
      locked <= 1'b0;
    end else if (ce_i) begin
      pc     <= next_pc;
      code   <= next_code;
      entry  <= next_entry;
      digit  <= next_digit;
      idx    <= next_idx;
      locked <= next_locked;
    end
  end

  assign param_inc_o   = keys_i.up && !keys_i.lock_sel && !locked;
  assign param_dec_o   = keys_i.down && !keys_i.lock_sel && !locked;
  // display shows On while the passcode lock is set
  assign lock_on_o     = locked;
  assign entry_digit_o = digit;
  assign entry_idx_o   = idx;

  // ---------------- overload accumulator
  logic        starting;
  logic [5:0]  act_class;
  logic        act_off;
  logic        both_off;
  logic [31:0] cur_pct, eff_pct, ss, heat;
  logic        pickup;
  logic        trip_evt;

  assign starting  = (starter_phase_i == mop_pkg::PH_KICK) ||
                     (starter_phase_i == mop_pkg::PH_ACCEL) ||
                     (starter_phase_i == mop_pkg::PH_RUN_PRE_UTS);
  // class picked by phase and select
  assign act_class = (cfg.indep && starting) ? cfg.start_class : cfg.run_class;
  assign act_off   = (act_class == 6'h0);
  assign both_off  = cfg.indep && cfg.start_class == 6'h0 && cfg.run_class == 6'h0;
  assign cur_pct   = ratio_pct(32'(current_i), 32'(cfg.flc));
  // unbalanced derate raises the effective current
  assign eff_pct   = ratio_pct(cur_pct, 32'((derate_i == 8'h0) ? mop_pkg::PCT_ONE : derate_i));
  // pickup is FLA times service factor
  assign pickup    = (starter_phase_i != mop_pkg::PH_STOPPED) && (cur_pct > 32'(cfg.sf));
  // square over class gives exact class seconds at 600 percent
  assign heat      = (eff_pct * eff_pct) / 32'(act_class);
  // steady level uses the derated current
  assign ss        = ((32'(cfg.hcr) * eff_pct) / 32'h64) * mop_pkg::CONT_PCT;
  assign trip_evt  = !trip && (next_content >= mop_pkg::CONT_FULL);

  always_comb begin
    next_content = content;
    if (tick_i) begin
      if (pickup && !act_off) begin
        next_content = content + heat;
      end else if (starter_phase_i == mop_pkg::PH_STOPPED) begin
        next_content = content - (content >> mop_pkg::COOL_SHIFT);
      end else if (content > ss) begin
        next_content = content - ((content - ss) >> mop_pkg::COOL_SHIFT);
      end else begin
        next_content = content + ((ss - content) >> mop_pkg::COOL_SHIFT);
      end
      // below pickup hot/cold tracking never trips
      // cooling stays free; only a rise past 99 percent is held back
      if (!pickup && next_content > mop_pkg::CONT_CLAMP && next_content > content) begin
        next_content = (content > mop_pkg::CONT_CLAMP) ? content : mop_pkg::CONT_CLAMP;
      end
    end
    if (next_content > mop_pkg::CONT_FULL) begin
      next_content = mop_pkg::CONT_FULL;
    end
    // disabled class clamps, both off zeroes
    if (both_off) begin
      next_content = 32'h0;
    end else if (act_off && next_content > mop_pkg::CONT_CLAMP) begin
      next_content = mop_pkg::CONT_CLAMP;
    end
  end

  always_comb begin
    next_trip      = trip;
    next_stop_prof = stop_prof;
    if (trip_evt) begin
      next_trip      = 1'b1;
      // controlled stop runs the profile first
      next_stop_prof = cfg.ctrl_stop;
    end else if (trip && content < mop_pkg::CONT_LOCK) begin
      next_trip = 1'b0;
    end
    if (stop_prof && starter_phase_i == mop_pkg::PH_STOPPED) begin
      next_stop_prof = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      content   <= 32'h0;
      trip      <= 1'b0;
      stop_prof <= 1'b0;
    end else if (ce_i) begin
      content   <= next_content;
      trip      <= next_trip;
      stop_prof <= next_stop_prof;
    end
  end

  assign alarm           = (content >= mop_pkg::CONT_ALARM);
  assign alarm_o         = alarm;
  assign trip_o          = trip;
  assign stop_profile_o  = stop_prof;
  assign stop_now_o      = trip && !stop_prof;
  assign start_inhibit_o = trip;
  assign content_pct_o   = 7'(content / mop_pkg::CONT_PCT);

  // overload trip takes the log entry; another fault in the same cycle is not logged
  mop_fault_log u_log (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .push_i    (trip_evt || fault_i),
    .code_i    (trip_evt ? mop_pkg::FAULT_OL : fault_code_i),
    .rd_idx_i  (4'((adr_i - mop_pkg::REG_LOG) >> 2)),
    .rd_data_o (log_rd),
    .newest_o  (log_newest)
  );

  // ---------------- checks
  a_keypad_lock_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    locked |-> !param_inc_o && !param_dec_o) else $error("edit passed while locked");
  a_modbus_write_refused: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr_take && param_adr && locked |=> exc == mop_pkg::EXC_ILLEGAL && $stable(cfg))
    else $error("locked write not refused");
  a_code_lock_store: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pc == PC_ENTRY && keys_i.lock_sel && keys_i.enter && idx == mop_pkg::DIGIT_LAST
    && !locked |=> locked && code == $past(full_entry)) else $error("code not stored");
  a_code_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pc == PC_ENTRY && keys_i.lock_sel && keys_i.enter && idx == mop_pkg::DIGIT_LAST
    && locked |=> locked == ($past(full_entry) != $past(code))) else $error("unlock wrong");
  a_fault_log_newest: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && trip_evt |=> log_newest == mop_pkg::FAULT_OL) else $error("trip not logged");
  a_trip_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !trip ##1 trip |-> content >= mop_pkg::CONT_FULL) else $error("early trip");
  a_stop_profile: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && trip_evt && cfg.ctrl_stop |=> stop_profile_o && !stop_now_o)
    else $error("profile skipped");
  a_lockout_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && trip && content >= mop_pkg::CONT_LOCK |=> start_inhibit_o)
    else $error("start allowed");
  a_disabled_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && both_off |=> content == 32'h0) else $error("content not zeroed");
  c_trip_seen: cover property (@(posedge clk_i) disable iff (rst_i) trip_evt);
  c_unlock_seen: cover property (@(posedge clk_i) disable iff (rst_i) $fell(locked));
  c_lockout_end: cover property (@(posedge clk_i) disable iff (rst_i) $fell(trip));
endmodule

// ===== testbench/mop_keypad_model.sv
// keypad operator model that keys in passcodes
`timescale 1ns/10ps
module mop_keypad_model (
  // clock
  input  wire logic          clk_i,
  // keys toward the block
  output mop_pkg::mop_keys_t keys_o
);
  initial keys_o = '0;

  // one-cycle key pulse, then one idle cycle
  task automatic tap(input int k);
    @(posedge clk_i);
    keys_o[k] <= 1'b1;
    @(posedge clk_i);
    keys_o[k] <= 1'b0;
  endtask

  // view or leave the passcode parameter
  task automatic hold_sel(input logic s);
    @(posedge clk_i);
    keys_o.lock_sel <= s;
  endtask

  task automatic enter_code(input logic [15:0] c);
    int d;
    hold_sel(1'b1);
    tap(1);
    for (int i = 3; i >= 0; i--) begin
      d = int'(c[i*4 +: 4]);
      // high digits are reached by wrapping downwards
      if (d > 5) begin
        repeat (10 - d) tap(2);
      end else begin
        repeat (d) tap(3);
      end
      tap(1);
    end
    hold_sel(1'b0);
  endtask
endmodule

// ===== testbench/mop_protect_test.sv
// self-checking bench of the overload protection block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; \
  if ((got) !== (ex)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module mop_protect_test;
  typedef struct {logic [31:0] v; logic [31:0] m;} mop_note_t;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic               clk_i;
  logic               rst_i;
  logic               req;
  logic               we;
  logic [7:0]         adr;
  logic [3:0]         sel;
  logic [31:0]        wdat;
  logic [31:0]        dat_o;
  logic               ack_o;
  mop_pkg::mop_keys_t keys;
  logic               inc;
  logic               dec;
  logic               lock_on;
  logic [15:0]        cur;
  mop_pkg::mop_phase_t phase;
  logic               fault;
  logic [7:0]         fcode;
  logic [6:0]         pct;
  logic               alarm_o;
  logic               trip_o;
  logic               prof;
  logic               stopn;
  logic               inh;
  logic               lk;
  logic               ce;
  logic               tick;
  logic [7:0]         derate;
  logic [3:0]         dig;
  logic [1:0]         didx;
  int                 failures;
  int                 checks_done;
  int                 n;
  int                 a;
  logic [15:0]        code;
  logic [7:0]         f1;
  logic [7:0]         f2;
  mop_note_t          notes[$];
  mop_note_t          nt;

  mop_protect dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(req), .stb_i(req), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .keys_i(keys), .param_inc_o(inc), .param_dec_o(dec), .lock_on_o(lock_on),
    .entry_digit_o(dig), .entry_idx_o(didx), .tick_i(tick), .current_i(cur),
    .derate_i(derate), .starter_phase_i(phase), .fault_i(fault), .fault_code_i(fcode),
    .content_pct_o(pct), .alarm_o(alarm_o), .trip_o(trip_o), .stop_profile_o(prof),
    .stop_now_o(stopn), .start_inhibit_o(inh)
  );
  mop_keypad_model kp (
    .clk_i(clk_i),
    .keys_o(keys)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic limit(input int k, input int lim);
    if (k >= lim) begin
      failures++;
      complete_run();
    end
  endtask

  // classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [7:0] ad, input logic [3:0] s,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    limit(k, 50);
    req <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v, m});
    wb(1'b0, ad, 4'hF, 32'h0000_0000);
  endtask

  task automatic pulse_fault(input logic [7:0] c);
    @(posedge clk_i);
    fault <= 1'b1;
    fcode <= c;
    @(posedge clk_i);
    fault <= 1'b0;
  endtask

  task automatic wait_trip(input int lim);
    n = 0;
    a = 0;
    while (trip_o !== 1'b1 && n < lim) begin
      @(negedge clk_i);
      n++;
      if (alarm_o === 1'b1 && a == 0) a = n;
    end
    limit(n, lim);
  endtask

  task automatic wait_free;
    n = 0;
    while (inh === 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    limit(n, 2000);
  endtask

  // read results and key edits are judged as they appear
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we === 1'b0) begin
      if (notes.size() == 0) `CHK("note", 1'b1, 1'b0)
      else begin
        nt = notes.pop_front();
        `CHK("rdata", nt.v & nt.m, dat_o & nt.m)
      end
    end
    if (keys.up && !keys.lock_sel) `CHK("inc", !lk, inc)
    if (keys.down && !keys.lock_sel) `CHK("dec", !lk, dec)
  end

  initial begin
    void'($urandom(32'h2cee));
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    cur = 16'h0000;
    phase = mop_pkg::PH_STOPPED;
    fault = 1'b0;
    fcode = 8'h00;
    ce = 1'b1;
    tick = 1'b1;
    derate = 8'h64;
    lk = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(mop_pkg::REG_CFG, 32'h0, ALL);
    rd(mop_pkg::REG_CLASS, {18'h0, mop_pkg::CLASS_RST, 2'h0, mop_pkg::CLASS_RST}, ALL);
    rd(mop_pkg::REG_FLC, {16'h0, mop_pkg::FLC_RST}, ALL);
    rd(mop_pkg::REG_SF, {24'h0, mop_pkg::SF_RST}, ALL);
    rd(mop_pkg::REG_HCR, {24'h0, mop_pkg::HCR_RST}, ALL);
    rd(mop_pkg::REG_STAT, 32'h0, ALL);
    rd(8'h18, 32'h0, ALL);
    `CHK("lock_on", 1'b0, lock_on)
    $display("test reset done");
    for (int i = 0; i < 4; i++) code[i*4 +: 4] = 4'($urandom % 10);
    kp.tap(3);
    kp.hold_sel(1'b1);
    kp.tap(1);
    repeat (2) kp.tap(3);
    kp.tap(1);
    kp.tap(2);
    @(negedge clk_i);
    `CHK("digit", 4'h9, dig)
    `CHK("index", 2'h1, didx)
    kp.hold_sel(1'b0);
    kp.enter_code(code);
    repeat (2) @(negedge clk_i);
    `CHK("lock_on", 1'b1, lock_on)
    lk = 1'b1;
    kp.tap(3);
    kp.tap(2);
    wb(1'b1, mop_pkg::REG_FLC, 4'h3, 32'h0000_00C8);
    rd(mop_pkg::REG_FLC, {16'h0, mop_pkg::FLC_RST}, ALL);
    rd(mop_pkg::REG_STAT, 32'h0003_0800, 32'h000F_0800);
    kp.enter_code(code ^ 16'h0001);
    repeat (2) @(negedge clk_i);
    `CHK("lock_on", 1'b1, lock_on)
    kp.enter_code(code);
    repeat (2) @(negedge clk_i);
    `CHK("lock_on", 1'b0, lock_on)
    lk = 1'b0;
    kp.tap(2);
    wb(1'b1, mop_pkg::REG_FLC, 4'h3, 32'h0000_0064);
    rd(mop_pkg::REG_STAT, 32'h0, 32'h000F_0800);
    $display("test passcode done");
    f1 = 8'($urandom % 200) + 8'h02;
    f2 = 8'($urandom % 200) + 8'h02;
    pulse_fault(f1);
    pulse_fault(f2);
    rd(mop_pkg::REG_LOG, {24'h0, f2}, 32'hFF);
    rd(mop_pkg::REG_LOG + 8'h04, {24'h0, f1}, 32'hFF);
    $display("test fault log done");
    wb(1'b1, mop_pkg::REG_CFG, 4'h1, 32'h0000_0002);
    wb(1'b1, mop_pkg::REG_CLASS, 4'h3, 32'h0000_0101);
    @(posedge clk_i);
    phase <= mop_pkg::PH_UP_TO_SPEED;
    cur <= 16'h0258;
    wait_trip(300);
    `CHK("alarm", 1'b1, a inside {[90:92]})
    `CHK("trip", 1'b1, n inside {[100:102]})
    `CHK("prof", 1'b1, prof)
    `CHK("stopn", 1'b0, stopn)
    `CHK("inh", 1'b1, inh)
    rd(mop_pkg::REG_LOG, {24'h0, mop_pkg::FAULT_OL}, 32'hFF);
    rd(mop_pkg::REG_LOG + 8'h04, {24'h0, f2}, 32'hFF);
    rd(mop_pkg::REG_STAT, 32'h0000_0600, 32'h0000_0600);
    @(posedge clk_i);
    phase <= mop_pkg::PH_STOPPED;
    cur <= 16'h0000;
    repeat (2) @(negedge clk_i);
    `CHK("prof", 1'b0, prof)
    `CHK("stopn", 1'b1, stopn)
    wait_free();
    `CHK("pct", 1'b1, pct inside {[7'd13:7'd14]})
    $display("test trip done");
    wb(1'b1, mop_pkg::REG_CLASS, 4'h3, 32'h0000_0001);
    @(posedge clk_i);
    phase <= mop_pkg::PH_UP_TO_SPEED;
    cur <= 16'h0258;
    repeat (400) @(negedge clk_i);
    `CHK("pct", 7'd99, pct)
    `CHK("trip", 1'b0, trip_o)
    wb(1'b1, mop_pkg::REG_CFG, 4'h1, 32'h0000_0001);
    wb(1'b1, mop_pkg::REG_CLASS, 4'h3, 32'h0000_0000);
    repeat (4) @(negedge clk_i);
    `CHK("pct", 7'd0, pct)
    $display("test disabled class done");
    wb(1'b1, mop_pkg::REG_SF, 4'h1, 32'h0000_0073);
    wb(1'b1, mop_pkg::REG_CLASS, 4'h3, 32'h0000_0101);
    @(posedge clk_i);
    cur <= 16'h0073;
    repeat (400) @(negedge clk_i);
    `CHK("trip", 1'b0, trip_o)
    `CHK("alarm", 1'b0, alarm_o)
    @(posedge clk_i);
    cur <= 16'h0074;
    wait_trip(3000);
    `CHK("trip", 1'b1, trip_o)
    $display("test pickup done");
    @(posedge clk_i);
    tick <= 1'b0;
    phase <= mop_pkg::PH_STOPPED;
    cur <= 16'h0000;
    repeat (20) @(negedge clk_i);
    `CHK("pct", 7'd100, pct)
    @(posedge clk_i);
    tick <= 1'b1;
    ce <= 1'b0;
    repeat (20) @(negedge clk_i);
    `CHK("pct", 7'd100, pct)
    @(posedge clk_i);
    ce <= 1'b1;
    wait_free();
    @(posedge clk_i);
    derate <= 8'h32;
    phase <= mop_pkg::PH_UP_TO_SPEED;
    cur <= 16'h0258;
    wait_trip(300);
    `CHK("derate", 1'b1, n inside {[21:24]})
    $display("test derate done");
    complete_run();
  end
endmodule
